// >>> src/iva_executor.sv
// Executor for interrupt control and two-variable arithmetic commands.
// Assumes host frame bytes and program commands come from logic on clk.
`timescale 1ns/1ps
module iva_executor
  import iva_pkg::*;
(
  input wire logic clk,
  input wire logic srst,
  input wire logic rxValid,
  input wire logic [7:0] rxData,
  output logic rxReady,
  output logic txValid,
  output logic [7:0] txData,
  input wire logic txReady,
  input wire logic progValid,
  input wire iva_pkg::iva_cmd_type progCmd,
  output logic progReady,
  input wire logic ctxSaveValid,
  input wire iva_pkg::iva_ctx_type ctxIn,
  output logic ctxRestore,
  output iva_pkg::iva_ctx_type ctxOut,
  output logic inHandler,
  output logic [NUM_INT-1:0] intArmed,
  input wire logic [4:0] vectNum,
  output logic [VEC_W-1:0] vectAddr,
  output logic [7:0] cmpFlags,
  input wire logic [7:0] awaddr,
  input wire logic awvalid,
  output logic awready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  input wire logic wvalid,
  output logic wready,
  output logic [1:0] bresp,
  output logic bvalid,
  input wire logic bready,
  input wire logic [7:0] araddr,
  input wire logic arvalid,
  output logic arready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  output logic rvalid,
  input wire logic rready,
  output logic irq
);
  import iva_pkg::*;

  function automatic logic mapped(input logic [7:0] a);
    mapped = (a <= REG_VAR_DATA) && (a[1:0] == 2'b00);
  endfunction : mapped

  iva_state_type state;
  iva_cmd_type cmd;
  logic fromHost;
  logic [7:0] frameAddr;
  logic [7:0] sumAcc;
  logic [7:0] rxSum;
  logic [3:0] byteIdx;
  logic [7:0] replyStatus;
  logic [7:0] replyInstr;
  logic [7:0] replySum;
  logic [31:0] varMem [NUM_VAR];
  logic [VEC_W-1:0] vectMem [NUM_INT];
  logic [NUM_INT-1:0] intEn;
  logic globalEn;
  iva_ctx_type ctxSaved;
  logic [7:0] targetAddr;
  logic [7:0] hostAddr;
  logic [NUM_EVT-1:0] evtStatus;
  logic [NUM_EVT-1:0] evtMask;
  logic [NUM_EVT-1:0] evtSet;
  logic [7:0] varIndex;
  logic awHeld;
  logic wHeld;
  logic [7:0] awAddrReg;
  logic [31:0] wDataReg;
  logic [3:0] wStrbReg;

  // Frame intake: address, instruction, type, bank, value MSB first, checksum.
  wire progTake = progValid && progReady;
  wire rxTake = rxValid && rxReady;
  assign progReady = (state == EX_RECV) && (byteIdx == 4'd0);
  assign rxReady = (state == EX_RECV) && !(progValid && byteIdx == 4'd0);
  wire lastByte = rxTake && (byteIdx == 4'(FRAME_LEN - 1));
  wire sumOk = (rxSum == sumAcc);
  wire addrOk = (frameAddr == targetAddr);

  // Operands of the variable-pair operation.
  // operand indexing
  wire [7:0] idxA = cmd.bank;
  wire [7:0] idxB = cmd.value[7:0];
  wire idxOk = (cmd.value[31:8] == 24'h00_0000);
  wire signed [31:0] opA = varMem[idxA];
  wire signed [31:0] opB = varMem[idxB];
  wire divZero = (opB == 32'sh0000_0000);
  wire isDivOp = (cmd.typ == 8'd3) || (cmd.typ == 8'd4);
  wire [63:0] product = 64'(opA * opB);
  wire intNumOk = (cmd.typ < 8'(NUM_INT));
  wire [4:0] intNum = cmd.typ[4:0];

  logic [31:0] arithRes;
  always_comb
  begin
    case (cmd.typ)
      8'd0: arithRes = 32'(opA + opB);
      8'd1: arithRes = 32'(opA - opB);
      8'd2: arithRes = product[31:0];
      8'd3: arithRes = divZero ? opA : 32'(opA / opB);
      8'd4: arithRes = divZero ? opA : 32'(opA % opB);
      8'd5: arithRes = opA & opB;
      8'd6: arithRes = opA | opB;
      8'd7: arithRes = opA ^ opB;
      8'd8: arithRes = ~opB;
      8'd9: arithRes = opB;
      8'd10: arithRes = opB;
      default: arithRes = opA;
    endcase
  end

  // Result status; a division by zero leaves the first variable untouched.
  wire isArith = (cmd.instr == VARIABLE_PAIR_ARITH_CMD);
  wire isKnown = isArith || (cmd.instr == INTERRUPT_UNMASK_CMD) ||
                 (cmd.instr == INTERRUPT_MASK_OFF_CMD) ||
                 (cmd.instr == HANDLER_ENTRY_DEFINE_CMD) || (cmd.instr == HANDLER_RETURN_CMD);
  wire badSum = fromHost && !sumOk;
  wire execOk = !badSum && isKnown && !(isArith && (cmd.typ > LAST_ARITH_OP || !idxOk));
  logic [7:0] execStatus;
  always_comb
  begin
    if (badSum)
      execStatus = ST_BAD_SUM;
    else if (!isKnown)
      execStatus = ST_BAD_CMD;
    else if (isArith && cmd.typ > LAST_ARITH_OP)
      execStatus = ST_BAD_TYPE;
    else if (isArith && !idxOk)
      execStatus = ST_BAD_VALUE;
    else
      execStatus = ST_OK;
  end
  wire doExec = (state == EX_EXEC) && execOk;

  // Sequencer.
  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      state <= EX_RECV;
      byteIdx <= 4'd0;
      fromHost <= 1'b0;
      sumAcc <= 8'h00;
      frameAddr <= 8'h00;
      rxSum <= 8'h00;
      cmd <= '0;
      replyStatus <= 8'h00;
      replyInstr <= 8'h00;
    end
    else
    begin
      case (state)
        EX_RECV:
        begin
          if (progTake)
          begin
            cmd <= progCmd;
            fromHost <= 1'b0;
            state <= EX_EXEC;
          end
          else if (rxTake)
          begin
            byteIdx <= lastByte ? 4'd0 : byteIdx + 4'd1;
            // The checksum byte itself stays out of the running sum.
            if (!lastByte)
              sumAcc <= (byteIdx == 4'd0) ? rxData : 8'(sumAcc + rxData);
            case (byteIdx)
              4'd0: frameAddr <= rxData;
              4'd1: cmd.instr <= rxData;
              4'd2: cmd.typ <= rxData;
              4'd3: cmd.bank <= rxData;
              4'd8: rxSum <= rxData;
              default: cmd.value <= {cmd.value[23:0], rxData};
            endcase
            fromHost <= 1'b1;
            // Frames for another address are dropped without an answer.
            if (lastByte && addrOk)
              state <= EX_EXEC;
          end
        end
        EX_EXEC:
        begin
          replyStatus <= execStatus;
          replyInstr <= cmd.instr;
          byteIdx <= 4'd0;
          state <= fromHost ? EX_REPLY : EX_RECV;
        end
        EX_REPLY:
        begin
          if (txReady)
          begin
            byteIdx <= (byteIdx == 4'(FRAME_LEN - 1)) ? 4'd0 : byteIdx + 4'd1;
            if (byteIdx == 4'(FRAME_LEN - 1))
              state <= EX_RECV;
          end
        end
        default: state <= EX_RECV;
      endcase
    end
  end

  // Reply: host, target, status, instruction, zero value, checksum.
  assign replySum = 8'(hostAddr + targetAddr + replyStatus + replyInstr);
  assign txValid = (state == EX_REPLY);
  always_comb
  begin
    case (byteIdx)
      4'd0: txData = hostAddr;
      4'd1: txData = targetAddr;
      4'd2: txData = replyStatus;
      4'd3: txData = replyInstr;
      4'd8: txData = replySum;
      default: txData = 8'h00;
    endcase
  end

  wire [31:0] wMask = {{8{wStrbReg[3]}}, {8{wStrbReg[2]}}, {8{wStrbReg[1]}}, {8{wStrbReg[0]}}};
  wire doWrite = awHeld && wHeld && !bvalid;
  wire [31:0] wBits = wDataReg & wMask;

  // Variable store; swap writes both indices in one cycle.
  // Software may preload a variable through the data register, but an arithmetic
  // command that writes a result in the same cycle wins and the bus write is lost.
  // result write back
  always_ff @(posedge clk)
  begin
    if (doExec && isArith && cmd.typ != LAST_ARITH_OP && !(isDivOp && divZero))
    begin
      varMem[idxA] <= arithRes;
      if (cmd.typ == 8'd10)
        varMem[idxB] <= opA;
    end
    else if (doWrite && awAddrReg == REG_VAR_DATA)
      varMem[varIndex] <= (varMem[varIndex] & ~wMask) | wBits;
  end

  // Interrupt enables, vectors and handler context.
  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      intEn <= '0;
      globalEn <= 1'b0;
      inHandler <= 1'b0;
      ctxRestore <= 1'b0;
      ctxSaved <= '0;
      ctxOut <= '0;
      cmpFlags <= 8'h00;
      for (int i = 0; i < NUM_INT; i++)
        vectMem[i] <= '0;
    end
    else
    begin
      ctxRestore <= 1'b0;
      if (ctxSaveValid)
      begin
        ctxSaved <= ctxIn;
        inHandler <= 1'b1;
      end
      if (doExec)
      begin
        case (cmd.instr)
          INTERRUPT_UNMASK_CMD:
            if (cmd.typ == GLOBAL_INT_NUM)
              globalEn <= 1'b1;
            else if (intNumOk)
              intEn[intNum] <= 1'b1;
          INTERRUPT_MASK_OFF_CMD:
            if (cmd.typ == GLOBAL_INT_NUM)
              globalEn <= 1'b0;
            else if (intNumOk)
              intEn[intNum] <= 1'b0;
          HANDLER_ENTRY_DEFINE_CMD:
            if (intNumOk)
              vectMem[intNum] <= cmd.value[VEC_W-1:0];
          HANDLER_RETURN_CMD:
            if (inHandler && !ctxSaveValid)
            begin
              ctxOut <= ctxSaved;
              ctxRestore <= 1'b1;
              inHandler <= 1'b0;
            end
          VARIABLE_PAIR_ARITH_CMD:
            if (cmd.typ == LAST_ARITH_OP)
              cmpFlags <= {6'b00_0000, opA < opB, opA == opB};
          default: ;
        endcase
      end
    end
  end
  // Handlers run only while both global and single enables are set.
  assign intArmed = globalEn ? intEn : '0;
  assign vectAddr = vectMem[vectNum];

  // Events. A handler return outside a handler means a program fell into one.
  // stray return detect
  always_comb
  begin
    evtSet = '0;
    evtSet[EVT_BAD_SUM] = (state == EX_EXEC) && badSum;
    evtSet[EVT_BAD_CMD] = (state == EX_EXEC) && !badSum && !isKnown;
    evtSet[EVT_DIV_ZERO] = doExec && isArith && isDivOp && divZero;
    evtSet[EVT_STRAY_RETURN] = doExec && (cmd.instr == HANDLER_RETURN_CMD) && !inHandler;
  end

  // Register slave; write address and data may arrive in either order.
  assign awready = !awHeld;
  assign wready = !wHeld;
  assign arready = !rvalid;
  assign irq = |(evtStatus & evtMask);

  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      awHeld <= 1'b0;
      wHeld <= 1'b0;
      awAddrReg <= 8'h00;
      wDataReg <= 32'h0000_0000;
      wStrbReg <= 4'h0;
      bvalid <= 1'b0;
      bresp <= 2'b00;
      rvalid <= 1'b0;
      rresp <= 2'b00;
      rdata <= 32'h0000_0000;
      targetAddr <= RST_TARGET_ADDR;
      hostAddr <= RST_HOST_ADDR;
      evtStatus <= '0;
      evtMask <= '0;
      varIndex <= 8'h00;
    end
    else
    begin
      if (awvalid && awready)
      begin
        awHeld <= 1'b1;
        awAddrReg <= awaddr;
      end
      if (wvalid && wready)
      begin
        wHeld <= 1'b1;
        wDataReg <= wdata;
        wStrbReg <= wstrb;
      end
      if (bvalid && bready)
        bvalid <= 1'b0;
      if (doWrite)
      begin
        awHeld <= 1'b0;
        wHeld <= 1'b0;
        bvalid <= 1'b1;
        bresp <= mapped(awAddrReg) ? 2'b00 : 2'b10;
        case (awAddrReg)
          REG_CTRL:
          begin
            targetAddr <= (targetAddr & ~wMask[7:0]) | wBits[7:0];
            hostAddr <= (hostAddr & ~wMask[15:8]) | wBits[15:8];
          end
          REG_EVT_MASK: evtMask <= (evtMask & ~wMask[NUM_EVT-1:0]) | wBits[NUM_EVT-1:0];
          REG_VAR_INDEX: varIndex <= (varIndex & ~wMask[7:0]) | wBits[7:0];
          default: ;
        endcase
      end
      // A new event wins over a write-one clear in the same cycle.
      evtStatus <= (evtStatus & ~((doWrite && awAddrReg == REG_EVT_STATUS) ?
                   wBits[NUM_EVT-1:0] : '0)) | evtSet;
      if (rvalid && rready)
        rvalid <= 1'b0;
      if (arvalid && arready)
      begin
        rvalid <= 1'b1;
        rresp <= mapped(araddr) ? 2'b00 : 2'b10;
        case (araddr)
          REG_CTRL: rdata <= {16'h0000, hostAddr, targetAddr};
          REG_STATE: rdata <= {24'h00_0000, cmpFlags[1:0], 4'h0, inHandler, globalEn};
          REG_INT_EN: rdata <= intEn;
          REG_EVT_STATUS: rdata <= 32'(evtStatus);
          REG_EVT_MASK: rdata <= 32'(evtMask);
          REG_VAR_INDEX: rdata <= 32'(varIndex);
          REG_VAR_DATA: rdata <= varMem[varIndex];
          default: rdata <= 32'h0000_0000;
        endcase
      end
    end
  end

endmodule : iva_executor

// >>> src/iva_pkg.sv
// Shared constants and types for the interrupt and variable-pair command executor.
// Assumes one 50 MHz clock and a synchronous active-high reset in every user.
package iva_pkg;

  localparam int CLK_HZ = 50_000_000;
  localparam int NUM_INT = 32;
  localparam int NUM_VAR = 256;
  localparam int FRAME_LEN = 9;
  localparam int VEC_W = 24;

  // Instruction codes handled here, the global interrupt number and the last arithmetic type.
  localparam logic [7:0] INTERRUPT_UNMASK_CMD = 8'd25;
  localparam logic [7:0] INTERRUPT_MASK_OFF_CMD = 8'd26;
  localparam logic [7:0] HANDLER_ENTRY_DEFINE_CMD = 8'd37;
  localparam logic [7:0] HANDLER_RETURN_CMD = 8'd38;
  localparam logic [7:0] VARIABLE_PAIR_ARITH_CMD = 8'd40;
  localparam logic [7:0] GLOBAL_INT_NUM = 8'd255;
  localparam logic [7:0] LAST_ARITH_OP = 8'd11;

  // Reply status codes.
  localparam logic [7:0] ST_OK = 8'd100;
  localparam logic [7:0] ST_BAD_SUM = 8'd1;
  localparam logic [7:0] ST_BAD_CMD = 8'd2;
  localparam logic [7:0] ST_BAD_TYPE = 8'd3;
  localparam logic [7:0] ST_BAD_VALUE = 8'd4;

  // Register byte offsets.
  localparam logic [7:0] REG_CTRL = 8'h00;
  localparam logic [7:0] REG_STATE = 8'h04;
  localparam logic [7:0] REG_INT_EN = 8'h08;
  localparam logic [7:0] REG_EVT_STATUS = 8'h0C;
  localparam logic [7:0] REG_EVT_MASK = 8'h10;
  localparam logic [7:0] REG_VAR_INDEX = 8'h14;
  localparam logic [7:0] REG_VAR_DATA = 8'h18;

  // Reset values.
  localparam logic [7:0] RST_TARGET_ADDR = 8'h01;
  localparam logic [7:0] RST_HOST_ADDR = 8'h02;

  // Event bits.
  localparam int EVT_BAD_SUM = 0;
  localparam int EVT_BAD_CMD = 1;
  localparam int EVT_DIV_ZERO = 2;
  localparam int EVT_STRAY_RETURN = 3;
  localparam int NUM_EVT = 4;

  typedef enum logic [1:0] {
    EX_RECV = 2'b00,
    EX_EXEC = 2'b01,
    EX_REPLY = 2'b11
  } iva_state_type;

  typedef struct packed {
    logic [7:0] instr;
    logic [7:0] typ;
    logic [7:0] bank;
    logic [31:0] value;
  } iva_cmd_type;

  typedef struct packed {
    logic [31:0] accu;
    logic [31:0] xreg;
    logic [7:0] flags;
    logic [VEC_W-1:0] pc;
  } iva_ctx_type;

endpackage : iva_pkg

// >>> verif/iva_asserts.sv
// Port-level checker for the interrupt and variable-pair executor.
// Assumes it is bound to iva_executor from the testbench top file.
`timescale 1ns/1ps
module iva_asserts
  import iva_pkg::*;
(
  input wire logic clk,
  input wire logic srst,
  input wire logic rxReady,
  input wire logic txValid,
  input wire logic [7:0] txData,
  input wire logic txReady,
  input wire logic progValid,
  input wire iva_pkg::iva_cmd_type progCmd,
  input wire logic progReady,
  input wire logic ctxSaveValid,
  input wire logic ctxRestore,
  input wire iva_pkg::iva_ctx_type ctxOut,
  input wire logic inHandler,
  input wire logic [NUM_INT-1:0] intArmed,
  input wire logic [4:0] vectNum,
  input wire logic [VEC_W-1:0] vectAddr
);
  default clocking @(posedge clk); endclocking
  default disable iff (srst);
  logic take;
  assign take = progValid && progReady;
  sequence progTake(logic [7:0] code);
    take && progCmd.instr == code;
  endsequence
  sequence vecDefined;
    progTake(HANDLER_ENTRY_DEFINE_CMD) ##0 progCmd.typ < 8'h20
    ##2 vectNum == $past(progCmd.typ[4:0], 2);
  endsequence
  chk_reply_holds: assert property (
    txValid && !txReady |=> txValid && $stable(txData)) else $error("reply byte dropped");
  chk_rx_blocked: assert property (
    txValid |-> !rxReady) else $error("frame byte taken during reply");
  chk_restore_once: assert property (
    ctxRestore |=> !ctxRestore) else $error("restore pulse too long");
  chk_restore_leaves: assert property (
    ctxRestore |-> !inHandler && $past(inHandler)) else $error("restore outside handler");
  chk_entry_sets: assert property (
    ctxSaveValid |=> inHandler) else $error("handler entry not seen");
  chk_ctx_holds: assert property (
    !ctxRestore && !$past(srst) |-> $stable(ctxOut)) else $error("context moved");
  chk_enable_one: assert property (
    progTake(INTERRUPT_UNMASK_CMD) ##0 progCmd.typ < 8'h20 |-> ##2
    (intArmed[$past(progCmd.typ[4:0], 2)] || intArmed == '0)) else $error("enable lost");
  chk_disable_one: assert property (
    progTake(INTERRUPT_MASK_OFF_CMD) ##0 progCmd.typ < 8'h20 |-> ##2
    !intArmed[$past(progCmd.typ[4:0], 2)]) else $error("disable lost");
  chk_disable_all: assert property (
    progTake(INTERRUPT_MASK_OFF_CMD) ##0 progCmd.typ == GLOBAL_INT_NUM |-> ##2
    intArmed == '0) else $error("global disable lost");
  chk_vector_store: assert property (
    vecDefined |-> vectAddr == $past(progCmd.value[VEC_W-1:0], 2)) else $error("vector lost");
endmodule : iva_asserts

// >>> verif/iva_host_model.sv
// Host that sends command frames and collects the replies.
// Assumes the executor's byte handshake on the same clock.
`timescale 1ns/1ps
module iva_host_model
  import iva_pkg::*;
(
  input wire logic clk,
  output logic rxValid,
  output logic [7:0] rxData,
  input wire logic rxReady,
  input wire logic txValid,
  input wire logic [7:0] txData,
  output logic txReady
);
  logic [7:0] reply [9];
  initial
  begin
    rxValid = 1'b0;
    rxData = 8'h00;
    txReady = 1'b0;
  end
  // indices arrive as given; frame with trailing checksum.
  task automatic sendFrame(input logic [7:0] tgt, ins, typ, bank, input logic [31:0] val,
                           input logic [7:0] bad);
    logic [7:0] b [9];
    logic ok;
    b = '{tgt, ins, typ, bank, val[31:24], val[23:16], val[15:8], val[7:0], 8'h00};
    for (int i = 0; i < 8; i++)
      b[8] += b[i];
    b[8] ^= bad;
    @(posedge clk);
    rxValid <= 1'b1;
    for (int i = 0; i < 9; i++)
    begin
      rxData <= b[i];
      ok = 1'b0;
      while (!ok)
      begin
        @(negedge clk);
        ok = rxReady;
        @(posedge clk);
      end
    end
    rxValid <= 1'b0;
    // A released line shows a fresh value so stale data cannot pass.
    rxData <= ~b[8];
  endtask : sendFrame
  task automatic getReply(input int stall);
    logic ok;
    @(posedge clk);
    for (int i = 0; i < 9; i++)
    begin
      repeat (stall) @(posedge clk);
      txReady <= 1'b1;
      ok = 1'b0;
      while (!ok)
      begin
        @(negedge clk);
        ok = txValid;
        reply[i] = txData;
        @(posedge clk);
      end
      if (stall > 0 || i == 8)
        txReady <= 1'b0;
    end
  endtask : getReply
endmodule : iva_host_model

// >>> verif/iva_tb.sv
// Self-checking bench for the executor with a host model and AXI4-Lite tasks.
// Assumes the package constants and the designer's register map.
`timescale 1ns/1ps
module tb;
  import iva_pkg::*;
  logic clk, srst, rxValid, rxReady, txValid, txReady, progValid, progReady, irq;
  logic ctxSaveValid, ctxRestore, inHandler, awvalid, awready, wvalid, wready, bvalid, bready;
  logic arvalid, arready, rvalid, rready;
  logic [7:0] rxData, txData, cmpFlags, awaddr, araddr;
  logic [1:0] bresp, rresp, lastResp;
  logic [3:0] wstrb;
  logic [4:0] vectNum;
  logic [31:0] wdata, rdata, rd;
  logic [NUM_INT-1:0] intArmed;
  logic [VEC_W-1:0] vectAddr;
  iva_cmd_type progCmd;
  iva_ctx_type ctxIn, ctxOut;
  int fails = 0;
  int checked = 0;
  int restoreSeen = 0;
  iva_executor iva_executor_inst (.clk, .srst, .rxValid, .rxData, .rxReady, .txValid, .txData,
    .txReady, .progValid, .progCmd, .progReady, .ctxSaveValid, .ctxIn, .ctxRestore, .ctxOut,
    .inHandler, .intArmed, .vectNum, .vectAddr, .cmpFlags, .awaddr, .awvalid, .awready, .wdata,
    .wstrb, .wvalid, .wready, .bresp, .bvalid, .bready, .araddr, .arvalid, .arready, .rdata,
    .rresp, .rvalid, .rready, .irq);
  iva_host_model iva_host_model_inst (.clk, .rxValid, .rxData, .rxReady, .txValid, .txData,
    .txReady);
  initial
  begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end
  always @(posedge clk)
    if (ctxRestore === 1'b1)
      restoreSeen++;
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp)
    begin
      fails++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check
  task automatic conclude();
    $display("checked=%0d fails=%0d", checked, fails);
    if (fails == 0 && checked > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask : conclude
  task automatic axiWrite(input logic [7:0] a, input logic [31:0] d);
    logic aw, w, b;
    @(posedge clk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    b = 1'b0;
    while (!b)
    begin
      @(negedge clk);
      aw = awvalid && awready;
      w = wvalid && wready;
      b = bvalid;
      lastResp = bresp;
      @(posedge clk);
      if (aw)
        awvalid <= 1'b0;
      if (w)
        wvalid <= 1'b0;
    end
    bready <= 1'b0;
  endtask : axiWrite
  task automatic axiRead(input logic [7:0] a);
    logic ar, r;
    @(posedge clk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    r = 1'b0;
    while (!r)
    begin
      @(negedge clk);
      ar = arvalid && arready;
      r = rvalid;
      rd = rdata;
      lastResp = rresp;
      @(posedge clk);
      if (ar)
        arvalid <= 1'b0;
    end
    rready <= 1'b0;
  endtask : axiRead
  task automatic progIssue(input logic [7:0] ins, typ, input logic [31:0] val);
    logic ok;
    @(posedge clk);
    progCmd <= '{instr: ins, typ: typ, bank: 8'h00, value: val};
    progValid <= 1'b1;
    ok = 1'b0;
    while (!ok)
    begin
      @(negedge clk);
      ok = progReady;
      @(posedge clk);
    end
    progValid <= 1'b0;
    repeat (2) @(posedge clk);
    @(negedge clk);
  endtask : progIssue
  task automatic cmdReply(input logic [7:0] tgt, ins, typ, bank, input logic [31:0] val,
                          input logic [7:0] bad, st, input int stall);
    logic [7:0] e [9];
    iva_host_model_inst.sendFrame(tgt, ins, typ, bank, val, bad);
    iva_host_model_inst.getReply(stall);
    e = '{8'h02, 8'h01, st, ins, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00};
    e[8] = 8'h02 + 8'h01 + st + ins;
    for (int i = 0; i < 8; i++)
      check(iva_host_model_inst.reply[i], e[i]);
    check(iva_host_model_inst.reply[8], e[8]);
  endtask : cmdReply
  task automatic setVar(input logic [7:0] idx, input logic [31:0] val);
    axiWrite(REG_VAR_INDEX, {24'h00_0000, idx});
    axiWrite(REG_VAR_DATA, val);
  endtask : setVar
  task automatic getVar(input logic [7:0] idx);
    axiWrite(REG_VAR_INDEX, {24'h00_0000, idx});
    axiRead(REG_VAR_DATA);
  endtask : getVar
  task automatic testReset();
    axiRead(REG_CTRL);
    check(rd, 32'h0000_0201);
    axiRead(8'h1C);
    check(rd, 32'h0000_0000);
    check(lastResp, 2'b10);
    axiWrite(8'h1C, 32'h0000_0001);
    check(lastResp, 2'b10);
    check(irq, 1'b0);
    check(intArmed, '0);
    $display("test reset done");
  endtask : testReset
  task automatic testEnable();
    cmdReply(8'h01, 8'd25, 8'd3, 8'h07, 32'h1234_5678, 8'h00, 8'd100, 0);
    axiRead(REG_INT_EN);
    check(rd, 32'h0000_0008);
    check(intArmed, '0);
    cmdReply(8'h01, 8'd25, 8'd255, 8'h00, 32'h0000_0000, 8'h00, 8'd100, 2);
    check(intArmed, 32'h0000_0008);
    progIssue(8'd25, 8'd9, 32'h0000_0000);
    check(intArmed, 32'h0000_0208);
    progIssue(8'd26, 8'd9, 32'h0000_0000);
    check(intArmed, 32'h0000_0008);
    cmdReply(8'h01, 8'd26, 8'd3, 8'h05, 32'h0000_0001, 8'h00, 8'd100, 0);
    cmdReply(8'h01, 8'd25, 8'd31, 8'h00, 32'h0000_0000, 8'h00, 8'd100, 0);
    check(intArmed, 32'h8000_0000);
    progIssue(8'd26, 8'd255, 32'h0000_0000);
    check(intArmed, '0);
    axiRead(REG_INT_EN);
    check(rd, 32'h8000_0000);
    $display("test enable done");
  endtask : testEnable
  task automatic testVector();
    vectNum <= 5'd4;
    progIssue(8'd37, 8'd4, 32'h0000_0050);
    check(vectAddr, 24'h00_0050);
    progIssue(8'd37, 8'd4, 32'h00AB_1234);
    check(vectAddr, 24'hAB_1234);
    vectNum <= 5'd5;
    cmdReply(8'h01, 8'd37, 8'd5, 8'h00, 32'h0000_0077, 8'h00, 8'd100, 1);
    check(vectAddr, 24'h00_0077);
    $display("test vector done");
  endtask : testVector
  task automatic testReturn();
    @(posedge clk);
    ctxIn <= '{accu: 32'h1111_2222, xreg: 32'h3333_4444, flags: 8'h5A, pc: 24'h00_0123};
    ctxSaveValid <= 1'b1;
    @(posedge clk);
    ctxSaveValid <= 1'b0;
    // the return is sent only after entry here.
    progIssue(8'd38, 8'd0, 32'h0000_0000);
    check(ctxOut.accu, 32'h1111_2222);
    check(ctxOut.xreg, 32'h3333_4444);
    check({ctxOut.flags, ctxOut.pc}, 32'h5A00_0123);
    check({restoreSeen[7:0], inHandler}, {8'h01, 1'b0});
    progIssue(8'd38, 8'd0, 32'h0000_0000);
    check({restoreSeen[7:0], irq}, {8'h01, 1'b0});
    axiWrite(REG_EVT_MASK, 32'h0000_0008);
    check(irq, 1'b1);
    axiWrite(REG_EVT_STATUS, 32'h0000_0008);
    check(lastResp, 2'b00);
    axiRead(REG_EVT_STATUS);
    check(rd, 32'h0000_0000);
    check(irq, 1'b0);
    $display("test return done");
  endtask : testReturn
  task automatic testArith();
    logic [31:0] want [12];
    // Results for first variable 100 and second variable 7, per operation.
    want = '{32'h0000_006B, 32'h0000_005D, 32'h0000_02BC, 32'h0000_000E, 32'h0000_0002,
      32'h0000_0004, 32'h0000_0067, 32'h0000_0063, 32'hFFFF_FFF8, 32'h0000_0007,
      32'h0000_0007, 32'h0000_0064};
    for (int op = 0; op < 12; op++)
    begin
      setVar(8'h41, 32'h0000_0064);
      setVar(8'h2A, 32'h0000_0007);
      cmdReply(8'h01, 8'd40, op[7:0], 8'h41, 32'h0000_002A, 8'h00, 8'd100, 0);
      getVar(8'h41);
      check(rd, want[op]);
      if (op == 10)
      begin
        getVar(8'h2A);
        check(rd, 32'h0000_0064);
      end
    end
    check(cmpFlags, 8'h00);
    // A negative first variable must compare below the second one.
    setVar(8'h41, 32'hFFFF_FFFF);
    cmdReply(8'h01, 8'd40, 8'd11, 8'h41, 32'h0000_002A, 8'h00, 8'd100, 0);
    check(cmpFlags, 8'h02);
    setVar(8'h2A, 32'h0000_0000);
    cmdReply(8'h01, 8'd40, 8'd3, 8'h41, 32'h0000_002A, 8'h00, 8'd100, 0);
    getVar(8'h41);
    check(rd, 32'hFFFF_FFFF);
    axiRead(REG_EVT_STATUS);
    check(rd, 32'h0000_0004);
    cmdReply(8'h01, 8'd40, 8'd12, 8'h41, 32'h0000_002A, 8'h00, ST_BAD_TYPE, 0);
    cmdReply(8'h01, 8'd40, 8'd0, 8'hFF, 32'h0000_0100, 8'h00, ST_BAD_VALUE, 0);
    cmdReply(8'h01, 8'd40, 8'd0, 8'h01, 32'h0000_0002, 8'h01, ST_BAD_SUM, 0);
    cmdReply(8'h01, 8'd7, 8'd0, 8'h00, 32'h0000_0000, 8'h00, ST_BAD_CMD, 0);
    iva_host_model_inst.sendFrame(8'h05, 8'd25, 8'd1, 8'h00, 32'h0000_0000, 8'h00);
    repeat (6) @(negedge clk);
    check(txValid, 1'b0);
    $display("test arith done");
  endtask : testArith
  initial
  begin
    srst = 1'b1;
    {progValid, ctxSaveValid, awvalid, wvalid, bready, arvalid, rready} = '0;
    {awaddr, araddr, wdata, vectNum, progCmd, ctxIn} = '0;
    wstrb = 4'hF;
    repeat (12) @(posedge clk);
    srst <= 1'b0;
    testReset();
    testEnable();
    testVector();
    testReturn();
    testArith();
    conclude();
  end
  initial
  begin
    repeat (20000) @(posedge clk);
    fails++;
    conclude();
  end
endmodule : tb
bind iva_executor iva_asserts iva_asserts_inst (.clk, .srst, .rxReady, .txValid, .txData,
  .txReady, .progValid, .progCmd, .progReady, .ctxSaveValid, .ctxRestore, .ctxOut, .inHandler,
  .intArmed, .vectNum, .vectAddr);
